// file: design/plmc_pkg.sv
package plmc_pkg;

   // ==========================================================
   // Register offsets (16-bit registers, word index)
   localparam logic [7:0] BASIC_CTRL_OFS   = 8'h00;
   localparam logic [7:0] BASIC_STAT_OFS   = 8'h01;
   localparam logic [7:0] ADVERT_OFS       = 8'h04;
   localparam logic [7:0] PARTNER_ABIL_OFS = 8'h05;
   localparam logic [7:0] EXPANSION_OFS    = 8'h06;
   localparam logic [7:0] GIG_CTRL_OFS     = 8'h09;
   localparam logic [7:0] GIG_STAT_OFS     = 8'h0a;
   localparam logic [7:0] DIAG_OFS         = 8'h24;
   localparam logic [7:0] LINK_MODE_OFS    = 8'h30;
   localparam logic [7:0] FILTER_BASE_OFS  = 8'h40;

   // ==========================================================
   // Basic control fields
   localparam int CTRL_SPEED_LSB_BIT = 13;
   localparam int CTRL_AN_EN_BIT     = 12;
   localparam int CTRL_AN_RESTART    = 9;
   localparam int CTRL_DUPLEX_BIT    = 8;
   localparam int CTRL_SPEED_MSB_BIT = 6;
   localparam logic [15:0] BASIC_CTRL_RST = 16'h1140;
   localparam logic [15:0] ADVERT_RST     = 16'h01e1;
   localparam logic [15:0] GIG_CTRL_RST   = 16'h0300;

   // Diagnostic fields
   localparam int DIAG_START_BIT = 15;
   localparam int DIAG_PAIR_LSB  = 12;
   localparam int DIAG_STAT_LSB  = 8;

   // ==========================================================
   // Emission filter tables
   localparam int FILTER_WORDS = 16;
   localparam logic [15:0] FILTER_ON [0:6] = '{16'h0001, 16'h0e03, 16'h3020,
      16'h2e36, 16'h0b1c, 16'h7e01, 16'h7f7e};
   localparam logic [15:0] FILTER_OFF [0:3] = '{16'h0000, 16'h1f0f, 16'h1f1f,
      16'h0010};

   // ==========================================================
   // Timing
   localparam int CLK_MHZ         = 125;
   localparam int DIAG_TIME_MS    = 250;
   localparam int DIAG_CYCLES     = DIAG_TIME_MS * CLK_MHZ * 1000;
   localparam int LINK_DOWN_CYCLES = 16;

   typedef enum logic [2:0] {
      PLMC_M_NONE   = 3'h0,
      PLMC_M_10HD   = 3'h1,
      PLMC_M_10FD   = 3'h2,
      PLMC_M_100HD  = 3'h3,
      PLMC_M_100FD  = 3'h4,
      PLMC_M_1000FD = 3'h5
   } plmc_mode_t;

   typedef enum logic [1:0] {
      PLMC_ST_DOWN  = 2'b00,
      PLMC_ST_MS    = 2'b01,
      PLMC_ST_UP    = 2'b11,
      PLMC_ST_DROP  = 2'b10
   } plmc_state_t;

   // Partner abilities as seen on the line
   typedef struct packed {
      logic       negotiating;
      logic       fixed_signal;
      logic       fixed_100;
      logic [4:0] abil;        // 1000FD,100FD,100HD,10FD,10HD
      logic       wants_master;
   } plmc_partner_t;

   typedef struct packed {
      logic       start;
      logic [1:0] pair;
   } plmc_diag_req_t;

endpackage

// file: design/plmc_link_mode.sv
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module plmc_link_mode
   import plmc_pkg::*;
#(
   parameter int DIAG_CYC = DIAG_CYCLES
) (
   input  wire logic          ref_clk,
   input  wire logic          rst,
   input  wire logic [7:0]    reg_addr,
   input  wire logic [15:0]   reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic      [15:0]   reg_rdata,
   input  wire logic          emission_filter_strap,
   input  wire logic          fast_linkup_strap,
   input  wire logic          fixed_speed_strap,
   input  wire logic          crossover_strap,
   input  wire plmc_partner_t partner_in,
   input  wire logic          diag_done,
   input  wire logic [1:0]    diag_result,
   input  wire logic [7:0]    diag_distance,
   output plmc_diag_req_t     diag_req,
   output logic               link_up,
   output plmc_mode_t         link_mode,
   output logic               is_master,
   output logic               auto_crossover_en,
   output logic               transmit_pair
);

   // ==========================================================
   // Input synchronisers
   logic [3:0]    strap_s1_reg, strap_s2_reg;
   plmc_partner_t part_s1_reg, part_s2_reg;
   logic [10:0]   diag_s1_reg, diag_s2_reg;
   always_ff @(posedge ref_clk) begin
      strap_s1_reg <= {emission_filter_strap, fast_linkup_strap, fixed_speed_strap,
                       crossover_strap};
      strap_s2_reg <= strap_s1_reg;
      part_s1_reg  <= partner_in;
      part_s2_reg  <= part_s1_reg;
      diag_s1_reg  <= {diag_done, diag_result, diag_distance};
      diag_s2_reg  <= diag_s1_reg;
   end

   // ==========================================================
   // Strap capture at reset release
   logic       rst_d_reg;
   logic       filt_en_reg, fast_reg, fix100_reg, xover_reg;
   always_ff @(posedge ref_clk) begin
      rst_d_reg <= rst;
      if (rst_d_reg && !rst) begin
         filt_en_reg <= strap_s2_reg[3];
         fast_reg    <= strap_s2_reg[2];
         fix100_reg  <= strap_s2_reg[1];
         xover_reg   <= strap_s2_reg[0];
      end
   end

   // ==========================================================
   // Control registers
   logic [15:0] ctrl_reg, adv_reg, gctl_reg;
   logic [15:0] lpa_reg, exp_reg, gstat_reg;
   logic [15:0] filt_reg [FILTER_WORDS];
   logic        restart_pulse, speed_chg;
   wire  [1:0]  spd_wr = {reg_wdata[CTRL_SPEED_MSB_BIT], reg_wdata[CTRL_SPEED_LSB_BIT]};
   wire  [1:0]  spd_cur = {ctrl_reg[CTRL_SPEED_MSB_BIT], ctrl_reg[CTRL_SPEED_LSB_BIT]};
   wire         ctrl_wr = reg_wr && reg_addr == BASIC_CTRL_OFS;
   assign restart_pulse = ctrl_wr && reg_wdata[CTRL_AN_RESTART];
   assign speed_chg     = ctrl_wr && spd_wr != spd_cur;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_reg <= BASIC_CTRL_RST;
         adv_reg  <= ADVERT_RST;
         gctl_reg <= GIG_CTRL_RST;
      end else if (reg_wr) begin
         if (ctrl_wr)
            ctrl_reg <= reg_wdata & ~(16'h0001 << CTRL_AN_RESTART);
         if (reg_addr == ADVERT_OFS)
            adv_reg <= reg_wdata;
         if (reg_addr == GIG_CTRL_OFS)
            gctl_reg <= reg_wdata;
      end
   end

   // Filter words load their strap table one cycle after reset release
   genvar gi;
   for (gi = 0; gi < FILTER_WORDS; gi++) begin : g_filt
      logic [15:0] on_val, off_val;
      // Words past the end of each table read as zero
      if (gi < $size(FILTER_ON)) begin : g_on
         assign on_val = FILTER_ON[gi];
      end else begin : g_on_zero
         assign on_val = 16'h0000;
      end
      if (gi < $size(FILTER_OFF)) begin : g_off
         assign off_val = FILTER_OFF[gi];
      end else begin : g_off_zero
         assign off_val = 16'h0000;
      end
      always_ff @(posedge ref_clk) begin
         if (rst_d_reg && !rst) begin
            if (strap_s2_reg[3])
               filt_reg[gi] <= on_val;
            else
               filt_reg[gi] <= off_val;
         end else if (reg_wr && reg_addr == FILTER_BASE_OFS + 8'(gi)) begin
            filt_reg[gi] <= reg_wdata;
         end
      end
   end

   // ==========================================================
   // Mode resolution
   logic [4:0]  own_abil;
   logic [4:0]  common;
   plmc_mode_t  best_an, forced_mode, pd_mode, target;
   logic        an_active;

   assign own_abil = {gctl_reg[9], adv_reg[8], adv_reg[7], adv_reg[6], adv_reg[5]};
   assign common   = own_abil & part_s2_reg.abil;
   // Fast link-up forces negotiation off regardless of the register
   assign an_active = ctrl_reg[CTRL_AN_EN_BIT] && !fast_reg;

   always_comb begin
      best_an = PLMC_M_NONE;
      if (common[4])      best_an = PLMC_M_1000FD;
      else if (common[3]) best_an = PLMC_M_100FD;
      else if (common[2]) best_an = PLMC_M_100HD;
      else if (common[1]) best_an = PLMC_M_10FD;
      else if (common[0]) best_an = PLMC_M_10HD;
   end

   always_comb begin
      // Speed 10 selects 1000, which cannot be forced: fall back to 100
      unique case (spd_cur)
         2'b00:   forced_mode = ctrl_reg[CTRL_DUPLEX_BIT] ? PLMC_M_10FD : PLMC_M_10HD;
         default: forced_mode = ctrl_reg[CTRL_DUPLEX_BIT] ? PLMC_M_100FD : PLMC_M_100HD;
      endcase
      if (fast_reg && fix100_reg && spd_cur != 2'b00)
         forced_mode = PLMC_M_100FD;
   end

   // Parallel detect only sees half-duplex 10 or 100 line signals
   assign pd_mode = part_s2_reg.fixed_100 ? PLMC_M_100HD : PLMC_M_10HD;

   always_comb begin
      target = PLMC_M_NONE;
      if (an_active) begin
         if (part_s2_reg.negotiating)
            target = best_an;
         else if (part_s2_reg.fixed_signal)
            target = pd_mode;
      end else if (part_s2_reg.negotiating || part_s2_reg.fixed_signal) begin
         target = forced_mode;
      end
   end

   // ==========================================================
   // Link state machine
   plmc_state_t state_reg;
   logic [4:0]  drop_cnt_reg;
   logic        link_seen;
   assign link_seen = part_s2_reg.negotiating || part_s2_reg.fixed_signal;

   // Held one cycle past reset so the freshly captured straps steer the first decision
   always_ff @(posedge ref_clk) begin
      if (rst || rst_d_reg) begin
         state_reg    <= PLMC_ST_DOWN;
         link_mode    <= PLMC_M_NONE;
         is_master    <= 1'b0;
         drop_cnt_reg <= '0;
      end else begin
         unique case (state_reg)
            PLMC_ST_DOWN: begin
               if (target != PLMC_M_NONE)
                  state_reg <= (target == PLMC_M_1000FD) ? PLMC_ST_MS : PLMC_ST_UP;
               link_mode <= target;
            end
            PLMC_ST_MS: begin
               // Master/slave settles before gigabit link comes up
               is_master <= gctl_reg[12] ? gctl_reg[11] : !part_s2_reg.wants_master;
               state_reg <= PLMC_ST_UP;
            end
            PLMC_ST_UP: begin
               if (speed_chg || restart_pulse || !link_seen) begin
                  state_reg    <= PLMC_ST_DROP;
                  drop_cnt_reg <= 5'(LINK_DOWN_CYCLES);
               end
            end
            PLMC_ST_DROP: begin
               link_mode <= PLMC_M_NONE;
               if (drop_cnt_reg == 5'd0)
                  state_reg <= PLMC_ST_DOWN;
               else
                  drop_cnt_reg <= drop_cnt_reg - 5'd1;
            end
         endcase
      end
   end
   assign link_up = (state_reg == PLMC_ST_UP);
   assign auto_crossover_en = !fast_reg;
   assign transmit_pair     = fast_reg ? xover_reg : 1'b0;

   // ==========================================================
   // Status and partner records
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lpa_reg   <= '0;
         exp_reg   <= '0;
         gstat_reg <= '0;
      end else if (!rst_d_reg && state_reg != PLMC_ST_UP && state_reg != PLMC_ST_DROP &&
                   target != PLMC_M_NONE && an_active && part_s2_reg.negotiating) begin
         lpa_reg   <= {7'h00, part_s2_reg.abil[3:0], 5'h01};
         exp_reg   <= 16'h0001;
         gstat_reg <= {4'h0, part_s2_reg.abil[4], 11'h000};
      end
   end

   // ==========================================================
   // Cable diagnostics
   logic        diag_busy_reg;
   logic [1:0]  diag_pair_reg, diag_stat_reg;
   logic [7:0]  diag_dist_reg;
   logic [31:0] diag_cnt_reg;
   logic        done_d_reg;
   wire         done_rise = diag_s2_reg[10] && !done_d_reg;
   wire         diag_start = reg_wr && reg_addr == DIAG_OFS && reg_wdata[DIAG_START_BIT];

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         diag_busy_reg <= 1'b0;
         diag_pair_reg <= 2'b00;
         diag_stat_reg <= 2'b00;
         diag_dist_reg <= 8'h00;
         diag_cnt_reg  <= '0;
         done_d_reg    <= 1'b0;
      end else begin
         done_d_reg <= diag_s2_reg[10];
         if (diag_start && !diag_busy_reg) begin
            diag_busy_reg <= 1'b1;
            diag_pair_reg <= reg_wdata[DIAG_PAIR_LSB +: 2];
            diag_cnt_reg  <= '0;
         end else if (diag_busy_reg) begin
            diag_cnt_reg <= diag_cnt_reg + 32'd1;
            if (done_rise) begin
               diag_busy_reg <= 1'b0;
               diag_stat_reg <= diag_s2_reg[9:8];
               diag_dist_reg <= diag_s2_reg[9] ^ diag_s2_reg[8] ? diag_s2_reg[7:0] : 8'h00;
            end else if (diag_cnt_reg >= 32'(DIAG_CYC - 1)) begin
               diag_busy_reg <= 1'b0;
               diag_stat_reg <= 2'b11;
               diag_dist_reg <= 8'h00;
            end
         end
      end
   end
   assign diag_req.start = diag_busy_reg;
   assign diag_req.pair  = diag_pair_reg;

   // ==========================================================
   // Read port
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= 16'h0000;
         if (reg_addr == BASIC_CTRL_OFS)   reg_rdata <= ctrl_reg;
         if (reg_addr == BASIC_STAT_OFS)   reg_rdata <= {13'h0000, link_up, 2'b00};
         if (reg_addr == ADVERT_OFS)       reg_rdata <= adv_reg;
         if (reg_addr == PARTNER_ABIL_OFS) reg_rdata <= lpa_reg;
         if (reg_addr == EXPANSION_OFS)    reg_rdata <= exp_reg;
         if (reg_addr == GIG_CTRL_OFS)     reg_rdata <= gctl_reg;
         if (reg_addr == GIG_STAT_OFS)     reg_rdata <= gstat_reg;
         if (reg_addr == DIAG_OFS)
            reg_rdata <= {diag_busy_reg, 1'b0, diag_pair_reg, 2'b00, diag_stat_reg,
                          diag_dist_reg};
         if (reg_addr == LINK_MODE_OFS)
            reg_rdata <= {8'h00, fast_reg, filt_en_reg, is_master, 2'b00, link_mode};
         if (reg_addr >= FILTER_BASE_OFS && reg_addr < FILTER_BASE_OFS + 8'(FILTER_WORDS))
            reg_rdata <= filt_reg[4'(reg_addr - FILTER_BASE_OFS)];
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // ==========================================================
   // Assertions
   // Gigabit bring-up: master/slave settles first, then the link comes up
   sequence gig_bringup_s;
      state_reg == PLMC_ST_MS ##1 state_reg == PLMC_ST_UP;
   endsequence
   // Hold-down count has run out
   sequence drop_end_s;
      state_reg == PLMC_ST_DROP && drop_cnt_reg == 5'd0;
   endsequence

   gig_needs_an_a: assert property (@(posedge ref_clk) disable iff (rst)
      link_mode == PLMC_M_1000FD |-> an_active)
      else $error("gigabit without negotiation");
   ms_before_up_a: assert property (@(posedge ref_clk) disable iff (rst)
      !rst_d_reg && state_reg == PLMC_ST_DOWN && target == PLMC_M_1000FD |=> gig_bringup_s)
      else $error("gigabit skipped master/slave");
   speed_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
      link_up && speed_chg |=> !link_up)
      else $error("link kept after speed change");
   drop_end_a: assert property (@(posedge ref_clk) disable iff (rst)
      drop_end_s |=> state_reg == PLMC_ST_DOWN && link_mode == PLMC_M_NONE)
      else $error("link drop did not end");
   restart_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
      link_up && restart_pulse |=> state_reg == PLMC_ST_DROP)
      else $error("restart did not drop link");
   restart_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
      ctrl_wr |=> !ctrl_reg[CTRL_AN_RESTART])
      else $error("restart bit kept");
   an_default_a: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(rst) |-> ctrl_reg[CTRL_AN_EN_BIT])
      else $error("negotiation off after reset");
   pd_half_a: assert property (@(posedge ref_clk) disable iff (rst)
      !rst_d_reg && state_reg == PLMC_ST_DOWN && an_active && !part_s2_reg.negotiating &&
      part_s2_reg.fixed_signal |=> link_mode == PLMC_M_100HD || link_mode == PLMC_M_10HD)
      else $error("parallel detect gave wrong mode");
   fast_no_xover_a: assert property (@(posedge ref_clk) disable iff (rst)
      fast_reg |-> !auto_crossover_en && !an_active)
      else $error("fast link-up left negotiation on");
   partner_rec_a: assert property (@(posedge ref_clk) disable iff (rst)
      !rst_d_reg && state_reg == PLMC_ST_DOWN && target != PLMC_M_NONE && an_active &&
      part_s2_reg.negotiating |=> gstat_reg[11] == $past(part_s2_reg.abil[4]))
      else $error("partner gigabit ability not recorded");
   filter_word0_a: assert property (@(posedge ref_clk) disable iff (rst)
      rst_d_reg |=> filt_reg[0] == (filt_en_reg ? FILTER_ON[0] : FILTER_OFF[0]))
      else $error("filter enable word wrong");
   diag_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
      diag_busy_reg && done_rise |=> !diag_busy_reg)
      else $error("diagnostic start bit not cleared");
   diag_start_a: assert property (@(posedge ref_clk) disable iff (rst)
      diag_start && !diag_busy_reg |=> diag_busy_reg && diag_pair_reg == $past(reg_wdata[13:12]))
      else $error("diagnostic pair not taken");
   diag_timeout_a: assert property (@(posedge ref_clk) disable iff (rst)
      diag_busy_reg && !done_rise && diag_cnt_reg >= 32'(DIAG_CYC - 1)
      |=> !diag_busy_reg && diag_stat_reg == 2'b11)
      else $error("diagnostic timeout not reported");
   diag_dist_a: assert property (@(posedge ref_clk) disable iff (rst)
      diag_stat_reg == 2'b00 || diag_stat_reg == 2'b11 |-> diag_dist_reg == 8'h00)
      else $error("distance shown without fault");
   best_rank_a: assert property (@(posedge ref_clk) disable iff (rst)
      common[4] |-> best_an == PLMC_M_1000FD)
      else $error("top mode not chosen");
   straps_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      !$past(rst_d_reg) |-> $stable({filt_en_reg, fast_reg, fix100_reg, xover_reg}))
      else $error("strap value changed");

endmodule // plmc_link_mode

// file: bench/plmc_far_end.sv
`timescale 1ns/1ns
module plmc_far_end
   import plmc_pkg::*;
(
   input  wire logic           ref_clk,
   input  wire plmc_partner_t  cfg,
   input  wire logic           answer_en,
   input  wire logic [7:0]     answer_lat,
   input  wire logic [1:0]     result,
   input  wire logic [7:0]     distance,
   input  wire plmc_diag_req_t diag_req,
   output plmc_partner_t       partner_in,
   output logic                diag_done,
   output logic [1:0]          diag_result,
   output logic [7:0]          diag_distance
);
   logic [7:0] cnt_reg;

   // ==========================================================
   // Line side: advertised abilities and master preference
   // Registered so the line state changes just after a rising edge
   always_ff @(posedge ref_clk) begin
      partner_in <= cfg;
   end

   // ==========================================================
   // Reflection answer; lines show garbage while no result stands
   always_ff @(posedge ref_clk) begin
      if (!diag_req.start) begin
         cnt_reg   <= 8'h00;
         diag_done <= 1'b0;
      end else if (answer_en && cnt_reg == answer_lat) begin
         diag_done <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end
   assign diag_result   = diag_done ? result : ~result;
   assign diag_distance = diag_done ? distance : ~distance;
endmodule // plmc_far_end

// file: bench/phy_link_mode_control_bench.sv
`timescale 1ns/1ns
module phy_link_mode_control_bench
   import plmc_pkg::*;
;
   localparam logic [4:0] AB [0:5] = '{5'h1f, 5'h10, 5'h0f, 5'h07, 5'h03, 5'h01};
   localparam plmc_mode_t MD [0:5] = '{PLMC_M_1000FD, PLMC_M_1000FD, PLMC_M_100FD,
      PLMC_M_100HD, PLMC_M_10FD, PLMC_M_10HD};
   logic           ref_clk   = 1'b0;
   logic           rst       = 1'b1;
   logic [7:0]     reg_addr  = 8'h00;
   logic [15:0]    reg_wdata = 16'h0000;
   logic           reg_wr    = 1'b0;
   logic           reg_rd    = 1'b0;
   logic [3:0]     strap     = 4'h0; // Filter, fast, fixed speed, crossover
   plmc_partner_t  pcfg      = '0;
   logic           ans_en    = 1'b0;
   logic [7:0]     ans_lat   = 8'h04;
   logic [1:0]     ans_res   = 2'b00;
   logic [7:0]     ans_dist  = 8'h00;
   logic [15:0]    reg_rdata;
   logic [15:0]    rd;
   plmc_partner_t  partner_in;
   logic           diag_done;
   logic [1:0]     diag_result;
   logic [7:0]     diag_distance;
   plmc_diag_req_t diag_req;
   plmc_mode_t     link_mode;
   logic           link_up;
   logic           is_master;
   logic           auto_crossover_en;
   logic           transmit_pair;
   int             n_fail = 0;
   int             checks = 0;

   always #4 ref_clk = ~ref_clk;

   plmc_link_mode #(.DIAG_CYC(100)) dut (.ref_clk(ref_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .emission_filter_strap(strap[3]),
      .fast_linkup_strap(strap[2]), .fixed_speed_strap(strap[1]),
      .crossover_strap(strap[0]), .partner_in(partner_in), .diag_done(diag_done),
      .diag_result(diag_result), .diag_distance(diag_distance), .diag_req(diag_req),
      .link_up(link_up), .link_mode(link_mode), .is_master(is_master),
      .auto_crossover_en(auto_crossover_en), .transmit_pair(transmit_pair));

   plmc_far_end far (.ref_clk(ref_clk), .cfg(pcfg), .answer_en(ans_en),
      .answer_lat(ans_lat), .result(ans_res), .distance(ans_dist),
      .diag_req(diag_req), .partner_in(partner_in), .diag_done(diag_done),
      .diag_result(diag_result), .diag_distance(diag_distance));

   // ==========================================================
   // Shared tasks
   task automatic finish_test();
      $display("checks %0d, n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic ran_out();
      $display("unexpected at %0t: wait ran out", $time);
      n_fail++;
      finish_test();
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      rd = reg_rdata;
   endtask
   task automatic wait_link(input logic lvl);
      int i;
      for (i = 0; i < 400 && link_up !== lvl; i++)
         @(negedge ref_clk);
      if (link_up !== lvl)
         ran_out();
   endtask
   task automatic relink();
      wait_link(1'b0);
      wait_link(1'b1);
   endtask
   task automatic do_reset(input logic [3:0] s);
      @(posedge ref_clk);
      rst   <= 1'b1;
      strap <= s;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic chk_filter(input logic on);
      int i;
      for (i = 0; i < FILTER_WORDS; i++) begin
         rd_reg(FILTER_BASE_OFS + 8'(i));
         check(rd, on ? (i < 7 ? FILTER_ON[i] : 16'h0000)
            : (i < 4 ? FILTER_OFF[i] : 16'h0000));
      end
   endtask
   task automatic poll_diag();
      int i;
      rd_reg(DIAG_OFS);
      check(16'(rd[15]), 16'h0001);
      for (i = 0; i < 200 && rd[15] !== 1'b0; i++)
         rd_reg(DIAG_OFS);
      if (rd[15] !== 1'b0)
         ran_out();
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset_values();
      do_reset(4'b1000);
      rd_reg(BASIC_CTRL_OFS);
      check(rd, 16'h1140);
      check({15'h0, link_up}, 16'h0000);
      chk_filter(1'b1);
      rd_reg(8'hff);
      check(rd, 16'h0000);
      $display("reset values done");
   endtask
   task automatic t_autoneg();
      int i;
      for (i = 0; i < 6; i++) begin
         pcfg <= {1'b1, 1'b1, 1'b1, AB[i], i[0]};
         wr(BASIC_CTRL_OFS, 16'h1340);
         relink();
         check(16'(link_mode), 16'(MD[i]));
         if (i < 2)
            check(16'(is_master), 16'(!i[0]));
         rd_reg(BASIC_STAT_OFS);
         check(16'(rd[2]), 16'h0001);
         rd_reg(GIG_STAT_OFS);
         check(16'(rd[11]), 16'(AB[i][4]));
         rd_reg(PARTNER_ABIL_OFS);
         check(16'(rd[8:5]), 16'(AB[i][3:0]));
      end
      $display("autoneg done");
   endtask
   task automatic t_hold();
      pcfg.abil <= 5'h0f;
      wr(BASIC_CTRL_OFS, 16'h1340);
      relink();
      pcfg.abil <= 5'h07;
      repeat (2 * LINK_DOWN_CYCLES) @(negedge ref_clk);
      check({link_up, 12'h0, link_mode}, {1'b1, 12'h0, PLMC_M_100FD});
      wr(BASIC_CTRL_OFS, 16'h1340);
      relink();
      check(16'(link_mode), 16'(PLMC_M_100HD));
      $display("hold done");
   endtask
   task automatic t_parallel();
      int i;
      for (i = 0; i < 2; i++) begin
         pcfg <= {1'b0, 1'b1, !i[0], 5'h1f, 1'b0};
         wr(BASIC_CTRL_OFS, 16'h1340);
         relink();
         check(16'(link_mode), i ? 16'(PLMC_M_10HD) : 16'(PLMC_M_100HD));
      end
      $display("parallel done");
   endtask
   task automatic t_forced();
      pcfg.fixed_100 <= 1'b1;
      wr(BASIC_CTRL_OFS, 16'h2100);
      relink();
      check(16'(link_mode), 16'(PLMC_M_100FD));
      wr(BASIC_CTRL_OFS, 16'h0140);
      repeat (2 * LINK_DOWN_CYCLES) @(negedge ref_clk);
      check(16'(link_mode === PLMC_M_1000FD), 16'h0000);
      pcfg.fixed_100 <= 1'b0;
      wr(BASIC_CTRL_OFS, 16'h0100);
      relink();
      check(16'(link_mode), 16'(PLMC_M_10FD));
      $display("forced done");
   endtask
   task automatic t_diag();
      int p;
      wr(BASIC_CTRL_OFS, 16'h0140);
      for (p = 0; p < 4; p++) begin
         ans_en   <= 1'b1;
         ans_lat  <= 8'h04 + 8'(p * 16);
         ans_res  <= p[1:0];
         ans_dist <= 8'h30 + 8'(p);
         wr(DIAG_OFS, 16'h8000 | 16'(p << 12));
         @(negedge ref_clk);
         check(16'(diag_req.pair), 16'(p));
         poll_diag();
         check(16'(rd[9:8]), 16'(p));
         check(16'(rd[7:0]), (p == 1 || p == 2) ? 16'h0030 + 16'(p) : 16'h0000);
      end
      ans_en <= 1'b0;
      wr(DIAG_OFS, 16'h8000);
      poll_diag();
      check(rd[9:0], 10'h300);
      $display("diag done");
   endtask
   task automatic t_fast();
      pcfg <= {1'b0, 1'b1, 1'b1, 5'h1f, 1'b0};
      do_reset(4'b0111);
      check({auto_crossover_en, transmit_pair}, 2'b01);
      chk_filter(1'b0);
      wait_link(1'b1);
      check(16'(link_mode), 16'(PLMC_M_100FD));
      rd_reg(LINK_MODE_OFS);
      check(16'(rd[7:6]), 16'h0002);
      @(posedge ref_clk);
      strap <= 4'b1000;
      repeat (4) @(posedge ref_clk);
      rd_reg(LINK_MODE_OFS);
      check({rd[7:6], auto_crossover_en, transmit_pair}, 4'b1001);
      pcfg.fixed_100 <= 1'b0;
      wr(BASIC_CTRL_OFS, 16'h0100);
      relink();
      check(16'(link_mode), 16'(PLMC_M_10FD));
      $display("fast link-up done");
   endtask

   initial begin
      t_reset_values();
      t_autoneg();
      t_hold();
      t_parallel();
      t_forced();
      t_diag();
      t_fast();
      finish_test();
   end
endmodule // phy_link_mode_control_bench
